// File: verilog/pmwc_regs.vh
// Constants of the power mode and wake controller
`ifndef PMWC_REGS_VH
`define PMWC_REGS_VH

`define PMWC_REF_FREQ_HZ   250000000
`define PMWC_LRC_FREQ_HZ   32000

`define PMWC_ADDR_SYSCLK   8'h00
`define PMWC_ADDR_RC       8'h01
`define PMWC_ADDR_XTAL     8'h02
`define PMWC_ADDR_WDT      8'h03
`define PMWC_ADDR_PAWAKE   8'h04
`define PMWC_ADDR_STATUS   8'h05

`define PMWC_SCC_CKS_HI    7
`define PMWC_SCC_CKS_LO    5
`define PMWC_SCC_FHS       3
`define PMWC_SCC_FSS       2
`define PMWC_SCC_FKEEP     1
`define PMWC_SCC_SKEEP     0
`define PMWC_OSC_FLAG      1
`define PMWC_OSC_EN        0
`define PMWC_WS_HI         2
`define PMWC_WS_LO         0
`define PMWC_ST_PDF        0
`define PMWC_ST_TO         1

`define PMWC_SCC_RST       8'h00
`define PMWC_RCEN_RST      1'b1
`define PMWC_XTEN_RST      1'b0
`define PMWC_WS_RST        3'h3
`define PMWC_CKS_SLOW      3'h7

`define PMWC_WS_2P8        3'h0
`define PMWC_WS_2P10       3'h1
`define PMWC_WS_2P12       3'h2
`define PMWC_WS_2P14       3'h3
`define PMWC_EXP_2P8       5'h08
`define PMWC_EXP_2P10      5'h0a
`define PMWC_EXP_2P12      5'h0c
`define PMWC_EXP_2P14      5'h0e
`define PMWC_EXP_BASE      5'h0b

`define PMWC_S_RUN         2'h0
`define PMWC_S_LOWPWR      2'h1
`define PMWC_S_WAKE        2'h2

`endif

// File: verilog/pmwc_sync.v
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module pmwc_sync #(
  parameter W = 8
) (
  input  wire         ref_clk,
  input  wire         sys_rst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          sync_r <= meta_r;
        end
      end
      assign sync_out[i] = sync_r;
    end
  endgenerate
endmodule

// File: verilog/pmwc_osc_settle.v
// Oscillator start-up model with stable flag
`timescale 1ns/1ps
module pmwc_osc_settle #(
  parameter SETTLE_CYC = 64
) (
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire osc_on,
  output wire stable
);
  reg [15:0] cnt_r;
  reg        stable_r;

  // Flag drops while off and rises only after the full settle count
  always @(posedge ref_clk) begin
    if (sys_rst || !osc_on) begin
      cnt_r    <= 16'h0000;
      stable_r <= 1'b0;
    end else if (cnt_r == SETTLE_CYC[15:0] - 16'h0001) begin
      stable_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  assign stable = stable_r;
endmodule

// File: verilog/pmwc_top.v
// Power mode, wake-up and watchdog clock controller
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "pmwc_regs.vh"
module pmwc_top #(
  parameter LRC_DIV    = `PMWC_REF_FREQ_HZ / `PMWC_LRC_FREQ_HZ,
  parameter RC_SETTLE  = 64,
  parameter XT_SETTLE  = 256,
  parameter PA_W       = 8,
  parameter IRQ_W      = 4
) (
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire [7:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [7:0]       reg_rdata,
  input  wire             halt_exec,
  input  wire             wdt_clear_exec,
  input  wire             stack_full,
  input  wire [IRQ_W-1:0] irq_req,
  input  wire [IRQ_W-1:0] irq_enable,
  input  wire [PA_W-1:0]  port_a_pin,
  output wire             sys_clk_en,
  output wire             slow_clk_en,
  output wire             low_rc_clk_en,
  output wire             core_halted,
  output wire             io_hold,
  output wire             mem_hold,
  output reg              core_resume,
  output reg              core_int_service,
  output reg              core_pc_sp_reset,
  output reg              wdt_device_reset,
  output wire             fast_rc_osc_on,
  output wire             fast_xtal_osc_on,
  output wire             slow_osc_on,
  output wire             slow_src_crystal,
  output wire             power_down_flag,
  output wire             watchdog_timeout_flag
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg [7:0]       scc_r;
  reg             rc_en_r;
  reg             xt_en_r;
  reg [2:0]       ws_r;
  reg [PA_W-1:0]  pa_wake_en_r;
  reg             pdf_r;
  reg             to_r;
  reg [1:0]       state_r;
  reg [1:0]       state_nxt;
  reg             fast_keep_r;
  reg             slow_keep_r;
  reg [IRQ_W-1:0] irq_block_r;
  reg [PA_W-1:0]  pa_prev_r;
  reg             wake_int_r;
  reg             wake_wdt_r;
  reg [15:0]      lrc_cnt_r;
  reg [5:0]       fdiv_cnt_r;
  reg [18:0]      wdt_cnt_r;

  wire [2:0]       cks = scc_r[`PMWC_SCC_CKS_HI:`PMWC_SCC_CKS_LO];
  wire [PA_W-1:0]  pa_sync;
  wire [IRQ_W-1:0] irq_sync;
  wire             rc_stable;
  wire             xt_stable;

  ////////////////////////////////////////////////////////////////////////
  // Wake input synchronisers

  pmwc_sync #(
    .W (PA_W)
  ) u_pa_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (port_a_pin),
    .sync_out (pa_sync)
  );

  pmwc_sync #(
    .W (IRQ_W)
  ) u_irq_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (irq_req),
    .sync_out (irq_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Oscillator control

  wire in_lowpwr   = (state_r == `PMWC_S_LOWPWR);
  wire halted      = (state_r != `PMWC_S_RUN);
  // In the low-power state the keep bits decide which oscillators survive
  wire fast_allow  = !in_lowpwr || fast_keep_r;
  wire slow_allow  = !in_lowpwr || slow_keep_r;

  assign fast_rc_osc_on   = rc_en_r && fast_allow;
  assign fast_xtal_osc_on = xt_en_r && fast_allow;
  assign slow_osc_on      = slow_allow;
  assign slow_src_crystal = scc_r[`PMWC_SCC_FSS];

  pmwc_osc_settle #(
    .SETTLE_CYC (RC_SETTLE)
  ) u_rc_settle (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .osc_on  (fast_rc_osc_on),
    .stable  (rc_stable)
  );

  pmwc_osc_settle #(
    .SETTLE_CYC (XT_SETTLE)
  ) u_xt_settle (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .osc_on  (fast_xtal_osc_on),
    .stable  (xt_stable)
  );

  // Selected fast source is usable only once settled
  wire fast_ok = scc_r[`PMWC_SCC_FHS] ? xt_stable : rc_stable;

  ////////////////////////////////////////////////////////////////////////
  // Low-speed RC tick and clock dividers

  // Low RC clock is never gated: the watchdog always runs on it
  wire lrc_tick = (lrc_cnt_r == LRC_DIV[15:0] - 16'h0001);

  always @(posedge ref_clk) begin
    if (sys_rst || lrc_tick) begin
      lrc_cnt_r <= 16'h0000;
    end else begin
      lrc_cnt_r <= lrc_cnt_r + 16'h0001;
    end
  end

  assign low_rc_clk_en = lrc_tick;
  // Slow clock shares the RC tick as time base for either source
  assign slow_clk_en   = lrc_tick && slow_allow;

  always @(posedge ref_clk) begin
    if (sys_rst || !fast_ok) begin
      fdiv_cnt_r <= 6'h00;
    end else begin
      fdiv_cnt_r <= fdiv_cnt_r + 6'h01;
    end
  end

  wire [5:0] fdiv_mask = (6'h01 << cks) - 6'h01;
  wire       fast_tick = fast_ok && ((fdiv_cnt_r & fdiv_mask) == fdiv_mask);

  // Core clock stops whenever halted; waits for settle after slow mode
  assign sys_clk_en = !halted && ((cks == `PMWC_CKS_SLOW) ? slow_clk_en : fast_tick);

  ////////////////////////////////////////////////////////////////////////
  // Watchdog

  reg [4:0] wdt_exp;
  always @* begin
    case (ws_r)
      `PMWC_WS_2P8:  wdt_exp = `PMWC_EXP_2P8;
      `PMWC_WS_2P10: wdt_exp = `PMWC_EXP_2P10;
      `PMWC_WS_2P12: wdt_exp = `PMWC_EXP_2P12;
      `PMWC_WS_2P14: wdt_exp = `PMWC_EXP_2P14;
      default:       wdt_exp = `PMWC_EXP_BASE + {2'b00, ws_r};
    endcase
  end

  wire [18:0] wdt_term  = (19'h0_0001 << wdt_exp) - 19'h0_0001;
  wire        wdt_ovf   = lrc_tick && (wdt_cnt_r == wdt_term);
  wire        halt_take = halt_exec && (state_r == `PMWC_S_RUN);

  always @(posedge ref_clk) begin
    if (sys_rst || halt_take || wdt_clear_exec || wdt_ovf) begin
      wdt_cnt_r <= 19'h0_0000;
    end else if (lrc_tick) begin
      wdt_cnt_r <= wdt_cnt_r + 19'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake detection

  wire [PA_W-1:0]  pa_fall  = pa_prev_r & ~pa_sync & pa_wake_en_r;
  wire [IRQ_W-1:0] irq_wake = irq_sync & ~irq_block_r;
  wire             int_ok   = |(irq_wake & irq_enable) && !stack_full;
  wire             wake_any = (|pa_fall) || (|irq_wake) || wdt_ovf;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pa_prev_r <= {PA_W{1'b0}};
    end else begin
      pa_prev_r <= pa_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode state machine

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `PMWC_S_RUN: begin
        if (halt_exec) begin
          state_nxt = `PMWC_S_LOWPWR;
        end
      end
      `PMWC_S_LOWPWR: begin
        if (wake_any) begin
          state_nxt = `PMWC_S_WAKE;
        end
      end
      `PMWC_S_WAKE: begin
        // Core restarts only on a usable clock
        if ((cks == `PMWC_CKS_SLOW) || fast_ok) begin
          state_nxt = `PMWC_S_RUN;
        end
      end
      default: state_nxt = `PMWC_S_RUN;
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r          <= `PMWC_S_RUN;
      fast_keep_r      <= 1'b0;
      slow_keep_r      <= 1'b0;
      irq_block_r      <= {IRQ_W{1'b0}};
      wake_int_r       <= 1'b0;
      wake_wdt_r       <= 1'b0;
      core_resume      <= 1'b0;
      core_int_service <= 1'b0;
      core_pc_sp_reset <= 1'b0;
      wdt_device_reset <= 1'b0;
    end else begin
      state_r          <= state_nxt;
      core_resume      <= 1'b0;
      core_int_service <= 1'b0;
      core_pc_sp_reset <= 1'b0;
      wdt_device_reset <= wdt_ovf && (state_r == `PMWC_S_RUN);
      if (halt_take) begin
        fast_keep_r <= scc_r[`PMWC_SCC_FKEEP];
        slow_keep_r <= scc_r[`PMWC_SCC_SKEEP];
        irq_block_r <= irq_sync;
      end
      if (in_lowpwr && wake_any) begin
        wake_wdt_r <= wdt_ovf;
        wake_int_r <= int_ok;
      end
      if ((state_r == `PMWC_S_WAKE) && (state_nxt == `PMWC_S_RUN)) begin
        // Timeout beats interrupt; pending interrupt stays with its source
        core_pc_sp_reset <= wake_wdt_r;
        core_int_service <= !wake_wdt_r && wake_int_r;
        core_resume      <= !wake_wdt_r && !wake_int_r;
      end
    end
  end

  assign core_halted = halted;
  assign mem_hold    = halted;
  assign io_hold     = halted;

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pdf_r <= 1'b0;
      to_r  <= 1'b0;
    end else begin
      if (halt_take) begin
        pdf_r <= 1'b1;
      end else if (wdt_clear_exec) begin
        pdf_r <= 1'b0;
      end
      if (wdt_ovf) begin
        to_r <= 1'b1;
      end else if (halt_take) begin
        to_r <= 1'b0;
      end
    end
  end

  assign power_down_flag       = pdf_r;
  assign watchdog_timeout_flag = to_r;

  ////////////////////////////////////////////////////////////////////////
  // Register port

  // Writes are taken even while halted; a halted core issues none
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      scc_r        <= `PMWC_SCC_RST;
      rc_en_r      <= `PMWC_RCEN_RST;
      xt_en_r      <= `PMWC_XTEN_RST;
      ws_r         <= `PMWC_WS_RST;
      pa_wake_en_r <= {PA_W{1'b0}};
    end else if (reg_wr) begin
      case (reg_addr)
        `PMWC_ADDR_SYSCLK: scc_r   <= reg_wdata & 8'hef;
        `PMWC_ADDR_RC:     rc_en_r <= reg_wdata[`PMWC_OSC_EN];
        `PMWC_ADDR_XTAL:   xt_en_r <= reg_wdata[`PMWC_OSC_EN];
        `PMWC_ADDR_WDT:    ws_r    <= reg_wdata[`PMWC_WS_HI:`PMWC_WS_LO];
        `PMWC_ADDR_PAWAKE: pa_wake_en_r <= reg_wdata[PA_W-1:0];
        default: ;
      endcase
    end
  end

  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    case (reg_addr)
      `PMWC_ADDR_SYSCLK: rd_val = scc_r;
      `PMWC_ADDR_RC:     rd_val = {6'h00, rc_stable, rc_en_r};
      `PMWC_ADDR_XTAL:   rd_val = {6'h00, xt_stable, xt_en_r};
      `PMWC_ADDR_WDT:    rd_val = {5'h00, ws_r};
      `PMWC_ADDR_PAWAKE: rd_val[PA_W-1:0] = pa_wake_en_r;
      `PMWC_ADDR_STATUS: rd_val = {6'h00, to_r, pdf_r};
      default:           rd_val = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// File: verification/pmwc_asserts.sv
// Port checker of the power mode and wake controller
`timescale 1ns/1ps
module pmwc_asserts #(
  parameter LRC_DIV = 4
) (
  input wire       ref_clk,
  input wire       sys_rst,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       halt_exec,
  input wire       wdt_clear_exec,
  input wire       sys_clk_en,
  input wire       low_rc_clk_en,
  input wire       core_halted,
  input wire       io_hold,
  input wire       mem_hold,
  input wire       core_resume,
  input wire       core_int_service,
  input wire       core_pc_sp_reset,
  input wire       wdt_device_reset,
  input wire       power_down_flag,
  input wire       watchdog_timeout_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Cycles since last low RC tick; first gap after reset is unknown
  logic [15:0] gap_r;
  logic        seen_r;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b0;
    end else if (low_rc_clk_en) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////
  entry_flags_a: assert property (halt_exec && !core_halted && !low_rc_clk_en
    |=> core_halted && power_down_flag && !watchdog_timeout_flag) else $error("halt entry flags wrong");
  flag_clear_a: assert property ($fell(power_down_flag) |-> $past(wdt_clear_exec))
    else $error("power down flag cleared without clear instruction");
  halt_clock_a: assert property (core_halted |-> !sys_clk_en) else $error("core clock runs while halted");
  state_hold_a: assert property (core_halted |-> io_hold && mem_hold) else $error("hold missing while halted");
  wake_cause_a: assert property ($fell(core_halted)
    |-> $onehot({core_resume, core_int_service, core_pc_sp_reset})) else $error("release without one wake cause");
  wd_wake_a: assert property (core_pc_sp_reset |-> watchdog_timeout_flag && power_down_flag)
    else $error("watchdog wake flags wrong");
  run_reset_a: assert property (wdt_device_reset |-> !$past(core_halted))
    else $error("full reset requested from low power");
  tick_gap_a: assert property (low_rc_clk_en && seen_r |-> gap_r == 16'(LRC_DIV - 1))
    else $error("low RC tick spacing wrong");
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
endmodule
bind pmwc_top pmwc_asserts #(.LRC_DIV(LRC_DIV)) i_pmwc_asserts (.ref_clk, .sys_rst, .reg_rd, .reg_rdata,
  .halt_exec, .wdt_clear_exec, .sys_clk_en, .low_rc_clk_en, .core_halted, .io_hold, .mem_hold, .core_resume,
  .core_int_service, .core_pc_sp_reset, .wdt_device_reset, .power_down_flag, .watchdog_timeout_flag);

// File: verification/pmwc_pins_model.sv
// Port A pins with pull-ups and interrupt request sources
`timescale 1ns/1ps
module pmwc_pins_model (
  input  wire [7:0] pull_lo,
  input  wire [3:0] irq_set,
  output wire [7:0] port_a_pin,
  output wire [3:0] irq_req
);
  // Released pins float up to the pull-up level
  assign port_a_pin = ~pull_lo;
  // Source keeps its flag up until served, so pending lives here
  assign irq_req = irq_set;
endmodule

// File: verification/pmwc_top_bench.sv
// Self-checking bench of the power mode and wake controller
`timescale 1ns/1ps
`include "pmwc_regs.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module pmwc_top_bench;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       halt_exec = 1'b0;
  logic       wdt_clear_exec = 1'b0;
  logic       stack_full = 1'b0;
  logic [3:0] irq_set = 4'h0;
  logic [3:0] irq_enable = 4'h0;
  logic [7:0] pull_lo = 8'h00;
  wire  [7:0] reg_rdata;
  wire  [7:0] port_a_pin;
  wire  [3:0] irq_req;
  wire        sys_clk_en, low_rc_clk_en, core_halted, io_hold, mem_hold;
  wire        core_resume, core_int_service, core_pc_sp_reset, fast_rc_osc_on, slow_osc_on;
  wire        slow_clk_en, wdt_device_reset, fast_xtal_osc_on, slow_src_crystal;
  int         fail_count = 0;
  int         total_checks = 0;
  always #2 ref_clk = ~ref_clk;
  pmwc_pins_model i_pmwc_pins_model (.pull_lo, .irq_set, .port_a_pin, .irq_req);
  // Short divider and settle counts keep the watchdog run near a thousand cycles
  pmwc_top #(.LRC_DIV(4), .RC_SETTLE(8), .XT_SETTLE(8)) i_pmwc_top (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .halt_exec, .wdt_clear_exec, .stack_full, .irq_req, .irq_enable, .port_a_pin,
    .sys_clk_en, .slow_clk_en, .low_rc_clk_en, .core_halted, .io_hold, .mem_hold, .core_resume,
    .core_int_service, .core_pc_sp_reset, .wdt_device_reset, .fast_rc_osc_on, .fast_xtal_osc_on,
    .slow_osc_on, .slow_src_crystal, .power_down_flag(), .watchdog_timeout_flag());
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic halt;
    @(posedge ref_clk);
    halt_exec <= 1'b1;
    @(posedge ref_clk);
    halt_exec <= 1'b0;
    #1 `CHK("halted", 1'b1, core_halted)
  endtask
  task automatic wait_pulse(output logic [2:0] got, output int n);
    n = 0;
    got = 3'b000;
    while (got === 3'b000) begin
      @(posedge ref_clk);
      #1 got = {core_pc_sp_reset, core_int_service, core_resume};
      n++;
      if (n > 2000) begin
        fail_count++;
        wrap_up;
      end
    end
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] q;
    rd(`PMWC_ADDR_RC, q);
    `CHK("rc unsettled", 8'h01, q)
    rd(`PMWC_ADDR_WDT, q);
    `CHK("wdt reset", 8'h03, q)
    repeat (8) @(posedge ref_clk);
    rd(`PMWC_ADDR_RC, q);
    `CHK("rc settled", 8'h03, q)
    wr(8'h3c, 8'hff);
    rd(8'h3c, q);
    `CHK("unmapped", 8'h00, q)
    wr(`PMWC_ADDR_STATUS, 8'hff);
    rd(`PMWC_ADDR_STATUS, q);
    `CHK("status ro", 8'h00, q)
  endtask
  task automatic t_clock;
    logic [7:0] q;
    int         n;
    for (int c = 0; c < 8; c++) begin
      wr(`PMWC_ADDR_SYSCLK, 8'(c << 5));
      repeat (8) @(posedge ref_clk);
      n = 0;
      repeat (128) begin
        @(posedge ref_clk);
        #1 n += sys_clk_en;
      end
      `CHK("sysclk rate", (c == 7) ? 32 : (128 >> c), n)
    end
    // Fast oscillator stopped in slow mode, then back to fast
    wr(`PMWC_ADDR_RC, 8'h00);
    wr(`PMWC_ADDR_RC, 8'h01);
    wr(`PMWC_ADDR_SYSCLK, 8'h00);
    n = 0;
    repeat (3) begin
      @(posedge ref_clk);
      #1 n += sys_clk_en;
    end
    `CHK("unsettled clock", 0, n)
    repeat (8) @(posedge ref_clk);
    rd(`PMWC_ADDR_RC, q);
    `CHK("restart settled", 8'h03, q)
    // Crystal as fast source, slow source select bit
    wr(`PMWC_ADDR_XTAL, 8'h01);
    #1 `CHK("xtal on", 1'b1, fast_xtal_osc_on)
    rd(`PMWC_ADDR_XTAL, q);
    `CHK("xtal unsettled", 8'h01, q)
    wr(`PMWC_ADDR_SYSCLK, 8'h0c);
    #1 `CHK("slow src", 1'b1, slow_src_crystal)
    n = 0;
    repeat (3) begin
      @(posedge ref_clk);
      #1 n += sys_clk_en;
    end
    `CHK("xtal unsettled clock", 0, n)
    repeat (8) @(posedge ref_clk);
    n = 0;
    repeat (16) begin
      @(posedge ref_clk);
      #1 n += sys_clk_en;
    end
    `CHK("xtal clock", 16, n)
    rd(`PMWC_ADDR_XTAL, q);
    `CHK("xtal settled", 8'h03, q)
    wr(`PMWC_ADDR_XTAL, 8'h00);
    wr(`PMWC_ADDR_SYSCLK, 8'h00);
  endtask
  task automatic t_modes;
    logic [7:0] q;
    logic [2:0] got;
    int         n;
    int         s;
    wr(`PMWC_ADDR_PAWAKE, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wr(`PMWC_ADDR_SYSCLK, 8'(k));
      halt;
      `CHK("fast osc", k[1], fast_rc_osc_on)
      `CHK("slow osc", k[0], slow_osc_on)
      `CHK("held", 2'b11, {io_hold, mem_hold})
      n = 0;
      s = 0;
      repeat (8) begin
        @(posedge ref_clk);
        #1 n += low_rc_clk_en + sys_clk_en;
        s += slow_clk_en;
      end
      `CHK("wd ticks only", 2, n)
      `CHK("slow ticks", k[0] ? 2 : 0, s)
      rd(`PMWC_ADDR_STATUS, q);
      `CHK("entry flags", 8'h01, q)
      @(posedge ref_clk);
      pull_lo <= 8'h08;
      repeat (10) @(posedge ref_clk);
      #1 `CHK("masked pin", 1'b1, core_halted)
      @(posedge ref_clk);
      pull_lo <= 8'h0c;
      wait_pulse(got, n);
      `CHK("pin wake", 3'b001, got)
      @(posedge ref_clk);
      pull_lo <= 8'h00;
    end
  endtask
  task automatic t_irq;
    logic [2:0] got;
    int         n;
    @(posedge ref_clk);
    irq_enable <= 4'h3;
    irq_set    <= 4'h2;
    repeat (4) @(posedge ref_clk);
    halt;
    repeat (20) @(posedge ref_clk);
    #1 `CHK("stale irq", 1'b1, core_halted)
    @(posedge ref_clk);
    irq_set <= 4'h3;
    wait_pulse(got, n);
    `CHK("irq service", 3'b010, got)
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      irq_set    <= 4'h0;
      stack_full <= (i == 0);
      repeat (4) @(posedge ref_clk);
      halt;
      @(posedge ref_clk);
      irq_set <= (i == 0) ? 4'h1 : 4'h4;
      wait_pulse(got, n);
      `CHK("irq resume", 3'b001, got)
    end
  endtask
  task automatic t_wdog;
    logic [7:0] q;
    logic [2:0] got;
    int         n;
    wr(`PMWC_ADDR_WDT, 8'h00);
    halt;
    wait_pulse(got, n);
    `CHK("wd wake", 3'b100, got)
    `CHK("wd period", 1'b1, n >= 1016 && n <= 1040)
    rd(`PMWC_ADDR_STATUS, q);
    `CHK("wd flags", 8'h03, q)
    @(posedge ref_clk);
    wdt_clear_exec <= 1'b1;
    @(posedge ref_clk);
    wdt_clear_exec <= 1'b0;
    rd(`PMWC_ADDR_STATUS, q);
    `CHK("clear instr", 8'h02, q)
    // Overflow while running asks for a full reset instead
    n = 0;
    while (wdt_device_reset !== 1'b1 && n < 1100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK("run overflow", 1'b1, n >= 1010 && n <= 1030)
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_clock;
    t_modes;
    t_irq;
    t_wdog;
    wrap_up;
  end
endmodule
